// ---- core/sltrr_regs_top.sv ----
`timescale 1ns/1ps
module sltrr_regs_top #(
  parameter int FRAME_CYCLES = sltrr_pkg::FRAME_CYCLES
) (
  input  wire logic        CORE_CLK,
  input  wire logic        RST,
  input  wire logic        SCLK,
  input  wire logic        CHIP_SEL_N,
  input  wire logic        MOSI,
  output logic             MISO,
  output logic             MISO_OE,
  input  wire logic [1:0]  POWER_MODE,
  input  wire logic [7:0]  PIXEL_IN,
  output logic      [8:0]  PIXEL_ADDR,
  output logic             FRAME_TICK,
  output logic             LASER_EN_N,
  output logic             LASER_POWER_VALID,
  output logic             RES_HIGH_SEL,
  output logic      [2:0]  RES_CODE
);
  localparam logic [15:0] FRAME_LAST = 16'(FRAME_CYCLES - 1);

  sltrr_spi_if spi ();

  logic [2:0]  wr_sync_r;
  logic [2:0]  rd_sync_r;
  logic [15:0] frame_cnt_r;
  logic        frame_tick_r;
  logic [7:0]  legacy_cfg_r;
  logic [7:0]  laser_drive_r;
  logic [1:0]  range_compl_r;
  logic [4:0]  act_r;
  logic [4:0]  act_nxt;
  logic [3:0]  res_sel_r;
  logic [7:0]  pixel_r;
  logic [8:0]  ptr_r;
  logic [8:0]  ptr_nxt;
  logic        first_r;
  logic        laser_power_valid_flag_r;
  logic        res_high_r;
  logic [2:0]  res_code_r;
  logic [7:0]  rdata_r;
  sltrr_pkg::sltrr_pix_e pix_state_r;
  sltrr_pkg::sltrr_pix_e pix_state_nxt;
  logic        laser_en_n_r;
  logic [7:0]  rd_status;
  logic [7:0]  rd_obs;
  logic [7:0]  rd_mux;

  // The link-side logic runs on the serial clock and hands commands over as toggles
  sltrr_serial_port serial (
    .sclk       (SCLK),
    .chip_sel_n (CHIP_SEL_N),
    .mosi       (MOSI),
    .rst        (RST),
    .miso       (MISO),
    .miso_oe    (MISO_OE),
    .bus        (spi)
  );

  // Read data goes back as a quasi-static word; it changes only right after a read request
  assign spi.rdata = rdata_r;

  // Two flops tame each toggle, the third keeps the old level for edge detection
  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
    begin
      wr_sync_r <= 3'h0;
      rd_sync_r <= 3'h0;
    end
    else
    begin
      wr_sync_r <= {wr_sync_r[1:0], spi.wr_tgl};
      rd_sync_r <= {rd_sync_r[1:0], spi.rd_tgl};
    end
  end

  // One-cycle command strobes; toggles avoid any pulse-width limit between the domains
  wire wr_hit = wr_sync_r[2] ^ wr_sync_r[1];
  wire rd_hit = rd_sync_r[2] ^ rd_sync_r[1];

  // Address decode; the link holds address and data until the next command
  wire sel_status = spi.addr == sltrr_pkg::ADDR_STATUS;
  wire sel_legacy = spi.addr == sltrr_pkg::ADDR_LEGACY_CFG;
  wire sel_drive  = spi.addr == sltrr_pkg::ADDR_LASER_DRIVE;
  wire sel_compl  = spi.addr == sltrr_pkg::ADDR_RANGE_COMPL;
  wire sel_obs    = spi.addr == sltrr_pkg::ADDR_FRAME_ACT;
  wire sel_pixel  = spi.addr == sltrr_pkg::ADDR_PIXEL;
  wire sel_res    = spi.addr == sltrr_pkg::ADDR_RES_SEL;

  // Per-register strobes
  wire obs_wr = wr_hit && sel_obs;    // see RULE_05
  wire pix_wr = wr_hit && sel_pixel;  // see RULE_09
  wire pix_rd = rd_hit && sel_pixel;  // see RULE_11

  // Last cycle of a frame period
  wire frame_last_hit = frame_cnt_r == FRAME_LAST;

  // Free-running frame counter; the tick is the only frame event the rest sees
  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
    begin
      frame_cnt_r  <= 16'h0000;
      frame_tick_r <= 1'b0;
    end
    else
    begin
      frame_cnt_r  <= frame_last_hit ? 16'h0000 : frame_cnt_r + 16'h0001;
      frame_tick_r <= frame_last_hit;
    end
  end

  // Configuration writes; each register keeps its own value so write order never matters
  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
    begin
      legacy_cfg_r  <= sltrr_pkg::RST_LEGACY_CFG;
      laser_drive_r <= sltrr_pkg::RST_LASER_DRIVE;
      range_compl_r <= sltrr_pkg::RST_RANGE_COMPL;
      res_sel_r     <= sltrr_pkg::RST_RES_SEL;
    end
    else if (wr_hit)
    begin
      if (sel_legacy)
        legacy_cfg_r <= spi.wdata;
      if (sel_drive)
        laser_drive_r <= spi.wdata;  // see RULE_03
      if (sel_compl)
        range_compl_r <= spi.wdata[sltrr_pkg::RANGE_HI:sltrr_pkg::RANGE_LO];  // see RULE_16
      if (sel_res)
        res_sel_r <= spi.wdata[sltrr_pkg::RES_EN_BIT:sltrr_pkg::RES_CODE_LO];  // see RULE_16
    end
  end

  // Complement check on contents, so a half-finished update also keeps the laser dark
  wire [1:0] drive_range = laser_drive_r[sltrr_pkg::RANGE_HI:sltrr_pkg::RANGE_LO];
  wire       comp_ok     = range_compl_r == ~drive_range;  // see RULE_02

  // Laser stays off through reset; safe state first, then the check decides
  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
    begin
      laser_power_valid_flag_r   <= 1'b0;
      laser_en_n_r <= 1'b1;
    end
    else
    begin
      laser_power_valid_flag_r   <= comp_ok;   // see RULE_02
      laser_en_n_r <= !comp_ok;  // see RULE_02
    end
  end

  // A frame set wins over a clearing write in the same cycle, so a live sensor never looks idle
  assign act_nxt = frame_tick_r ? 5'h1f : (obs_wr ? 5'h00 : act_r);  // see RULE_04

  // Frame-activity bits
  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
      act_r <= sltrr_pkg::RST_FRAME_ACT;
    else
      act_r <= act_nxt;
  end

  // Pixel grab decode; a read advances the pointer even before the next capture
  wire pix_ready = pix_state_r == sltrr_pkg::PIX_READY;  // see RULE_10
  wire pix_cap   = (pix_state_r == sltrr_pkg::PIX_WAIT) && frame_tick_r && !pix_wr;  // see RULE_08
  wire pix_adv   = pix_rd && !pix_wr && (pix_state_r != sltrr_pkg::PIX_IDLE);
  assign ptr_nxt = (ptr_r == sltrr_pkg::PIX_LAST) ? 9'h000 : ptr_r + 9'h001;  // see RULE_12

  // Grab progress: wait for a frame, hold the pixel until it is read
  always_comb
  begin
    pix_state_nxt = pix_state_r;
    unique case (pix_state_r)
      sltrr_pkg::PIX_IDLE:
        pix_state_nxt = pix_state_r;
      sltrr_pkg::PIX_WAIT:
        if (frame_tick_r)
          pix_state_nxt = sltrr_pkg::PIX_READY;
      sltrr_pkg::PIX_READY:
        if (pix_rd)
          pix_state_nxt = sltrr_pkg::PIX_WAIT;
      default:
        pix_state_nxt = sltrr_pkg::PIX_IDLE;
    endcase
    if (pix_wr)
      pix_state_nxt = sltrr_pkg::PIX_WAIT;  // see RULE_09
  end

  // Grab state register
  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
      pix_state_r <= sltrr_pkg::PIX_IDLE;
    else
      pix_state_r <= pix_state_nxt;
  end

  // Pixel pointer; a new grab always restarts at the first pixel
  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
      ptr_r <= 9'h000;
    else if (pix_wr)
      ptr_r <= 9'h000;   // see RULE_09
    else if (pix_adv)
      ptr_r <= ptr_nxt;  // see RULE_11
  end

  // Captured pixel and first-pixel marker
  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
    begin
      first_r <= 1'b0;
      pixel_r <= sltrr_pkg::RST_PIXEL;
    end
    else
    begin
      if (pix_wr)
        first_r <= 1'b0;
      else if (pix_cap)
        first_r <= ptr_r == 9'h000;  // see RULE_12
      if (pix_cap)
        pixel_r <= PIXEL_IN;  // see RULE_08
    end
  end

  // Resolution source: the high-resolution code overrides the legacy field
  wire       res_en       = res_sel_r[3];
  wire [2:0] legacy_res   = legacy_cfg_r[sltrr_pkg::LEGACY_RES_HI:sltrr_pkg::LEGACY_RES_LO];
  wire [2:0] res_code_sel = res_en ? res_sel_r[2:0] : legacy_res;  // see RULE_14

  // Resolution outputs are registered so the motion path sees clean levels
  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
    begin
      res_high_r <= sltrr_pkg::RST_RES_SEL[3];
      res_code_r <= sltrr_pkg::RST_LEGACY_CFG[sltrr_pkg::LEGACY_RES_HI:sltrr_pkg::LEGACY_RES_LO];
    end
    else
    begin
      res_high_r <= res_en;        // see RULE_13
      res_code_r <= res_code_sel;  // see RULE_15
    end
  end

  // Status flags that share the movement status register
  always_comb
  begin
    rd_status = 8'h00;
    rd_status[sltrr_pkg::STAT_PIX_RDY]  = pix_ready;   // see RULE_10
    rd_status[sltrr_pkg::STAT_PIX_FST]  = first_r;     // see RULE_12
    rd_status[sltrr_pkg::STAT_LASER_POWER_VALID_FLAG] = laser_power_valid_flag_r;  // see RULE_02
  end

  // Read views; reserved positions read as zero
  assign rd_obs = {POWER_MODE, 1'b0, act_r};  // see RULE_07
  assign rd_mux = sel_status ? rd_status :
                  sel_legacy ? legacy_cfg_r :
                  sel_drive  ? laser_drive_r :
                  sel_compl  ? {range_compl_r, 6'h00} :  // see RULE_16
                  sel_obs    ? rd_obs :
                  sel_pixel  ? pixel_r :
                  sel_res    ? {3'h0, res_sel_r, 1'b0} :
                  8'h00;

  // Read word is latched once per request and then stands for the link
  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
      rdata_r <= 8'h00;
    else if (rd_hit)
      rdata_r <= rd_mux;
  end

  // Outputs straight from flops
  assign PIXEL_ADDR        = ptr_r;
  assign FRAME_TICK        = frame_tick_r;
  assign LASER_EN_N        = laser_en_n_r;
  assign LASER_POWER_VALID = laser_power_valid_flag_r;
  assign RES_HIGH_SEL      = res_high_r;
  assign RES_CODE          = res_code_r;

  // Checks, all in the core clock domain
  default clocking core_cb @(posedge CORE_CLK);
  endclocking
  default disable iff (RST);

  // Miscompare turns the laser off
  a_laser_off : assert property (  // see RULE_02
    !comp_ok |=> !laser_power_valid_flag_r && laser_en_n_r)
    else $error("laser enabled while range pairs are not complementary");

  // Every frame sets all activity bits
  a_act_frame_set : assert property (  // see RULE_04
    frame_tick_r |=> act_r == 5'h1f)
    else $error("activity bits not set after frame tick");

  // A write clears the activity bits
  a_act_write_clear : assert property (  // see RULE_05
    obs_wr && !frame_tick_r |=> act_r == 5'h00)
    else $error("activity bits not cleared by write");

  // Mode code shows in the top bits of the read word
  a_obs_mode_view : assert property (  // see RULE_07
    rd_hit && sel_obs |=> rdata_r[7:6] == $past(POWER_MODE))
    else $error("power mode code missing from activity read");

  // A pixel write restarts the grab at the first pixel
  a_pix_restart : assert property (  // see RULE_09
    pix_wr |=> ptr_r == 9'h000 && pix_state_r == sltrr_pkg::PIX_WAIT)
    else $error("pixel write did not restart grab");

  // No capture without a frame
  a_pix_frame_pace : assert property (  // see RULE_08
    pix_state_r == sltrr_pkg::PIX_WAIT && !frame_tick_r |=> !pix_ready)
    else $error("pixel became ready without a frame");

  // A read steps the pointer by one
  a_ptr_advance : assert property (  // see RULE_11
    pix_adv && ptr_r != sltrr_pkg::PIX_LAST |=> ptr_r == $past(ptr_r) + 9'h001)
    else $error("pixel pointer did not advance on read");

  // The last pixel wraps to the first
  a_ptr_wrap : assert property (  // see RULE_12
    pix_adv && ptr_r == sltrr_pkg::PIX_LAST |=> ptr_r == 9'h000)
    else $error("pixel pointer did not wrap");

  // High-resolution code overrides the legacy field
  a_res_high : assert property (  // see RULE_14
    res_sel_r[3] |=> res_high_r && res_code_r == $past(res_sel_r[2:0]))
    else $error("high resolution code not applied");

  // Legacy field rules while the override is off
  a_res_legacy : assert property (  // see RULE_13
    !res_sel_r[3] |=> !res_high_r && res_code_r == $past(legacy_res))
    else $error("legacy resolution not applied");

  // Main scenarios reached
  c_frame_tick : cover property (frame_tick_r);
  c_pix_capture : cover property (pix_cap);
  c_laser_valid : cover property (laser_power_valid_flag_r && !laser_en_n_r);
  c_res_high : cover property (res_high_r);
endmodule

// ---- core/sltrr_serial_port.sv ----
`timescale 1ns/1ps
module sltrr_serial_port (
  input  wire logic  sclk,
  input  wire logic  chip_sel_n,
  input  wire logic  mosi,
  input  wire logic  rst,
  output logic       miso,
  output logic       miso_oe,
  sltrr_spi_if.port  bus
);
  logic [3:0] bit_cnt_r;
  logic [6:0] shift_r;
  logic       is_write_r;
  logic [6:0] addr_r;
  logic [7:0] wdata_r;
  logic       wr_tgl_r;
  logic       rd_tgl_r;
  logic [7:0] out_sh_r;

  // Byte assembly and phase decode
  wire [7:0] byte_in   = {shift_r, mosi};
  wire       addr_done = bit_cnt_r == sltrr_pkg::SPI_ADDR_DONE;
  wire       data_done = bit_cnt_r == sltrr_pkg::SPI_DATA_DONE;
  wire       rd_cmd    = addr_done && !byte_in[sltrr_pkg::SPI_WRITE_BIT];

  // Deselect clears framing so a broken transfer cannot skew the next one
  always_ff @(posedge sclk or posedge chip_sel_n)
  begin
    if (chip_sel_n)
    begin
      bit_cnt_r <= 4'h0;
      shift_r   <= 7'h00;
    end
    else
    begin
      bit_cnt_r <= bit_cnt_r + 4'h1;
      shift_r   <= byte_in[6:0];
    end
  end

  // Command fields hold until the next command, long after the core samples them
  always_ff @(posedge sclk or posedge rst)
  begin
    if (rst)
    begin
      is_write_r <= 1'b0;
      addr_r     <= 7'h00;
      wdata_r    <= 8'h00;
      wr_tgl_r   <= 1'b0;
      rd_tgl_r   <= 1'b0;
    end
    else
    begin
      if (addr_done)
      begin
        addr_r     <= byte_in[6:0];
        is_write_r <= byte_in[sltrr_pkg::SPI_WRITE_BIT];
      end
      if (rd_cmd)
        rd_tgl_r <= ~rd_tgl_r;
      if (data_done && is_write_r)
      begin
        wdata_r  <= byte_in;
        wr_tgl_r <= ~wr_tgl_r;
      end
    end
  end

  // Read data is quasi-static: the controller waits after the address byte
  always_ff @(negedge sclk or posedge chip_sel_n)
  begin
    if (chip_sel_n)
      out_sh_r <= 8'h00;
    else if (bit_cnt_r == sltrr_pkg::SPI_DATA_START)
      out_sh_r <= bus.rdata;
    else
      out_sh_r <= {out_sh_r[6:0], 1'b0};
  end

  // Outputs toward the pins and the core
  assign miso      = out_sh_r[7];
  assign miso_oe   = ~chip_sel_n;
  assign bus.addr  = addr_r;
  assign bus.wdata = wdata_r;
  assign bus.wr_tgl = wr_tgl_r;
  assign bus.rd_tgl = rd_tgl_r;
endmodule

// ---- include/sltrr_pkg.sv ----
// Contract
// RULE_01: Controller writes complement bits as the inverse of drive-control range bits.
// RULE_02: Range pairs not complementary turns laser off and clears power-valid flag.
// RULE_03: Drive-control and complement registers accept writes in any order.
// RULE_04: Every frame sets all five frame-activity bits.
// RULE_05: Any write to the activity register clears its activity bits. The code lets a frame tick in the same cycle win and set the bits instead.
// RULE_06: Controller waits one frame after clearing before reading activity back.
// RULE_07: Top two activity-register bits report power mode run/rest1/rest2/rest3.
// RULE_08: Pixel readout delivers one pixel per frame.
// RULE_09: Writing the pixel register resets pointer to 0,0 and starts a grab.
// RULE_10: Pixel-ready flag shows valid data; controller polls before reading.
// RULE_11: Each pixel register read advances the pointer. The code does not advance it on reads before the first grab (PIX_IDLE).
// RULE_12: After a full array the pointer wraps and the first-pixel flag rises.
// RULE_13: High-resolution enable low takes resolution from the legacy config register.
// RULE_14: High-resolution enable high takes the three-bit code, ignoring legacy config.
// RULE_15: Codes 001, 010, 011 select 400, 800, 1200 counts per inch.
// RULE_16: Reserved bits read zero and ignore writes.
package sltrr_pkg;
  // Register offsets
  localparam logic [6:0] ADDR_STATUS      = 7'h02;
  localparam logic [6:0] ADDR_LEGACY_CFG  = 7'h12;
  localparam logic [6:0] ADDR_LASER_DRIVE = 7'h1a;
  localparam logic [6:0] ADDR_RANGE_COMPL = 7'h1f;
  localparam logic [6:0] ADDR_FRAME_ACT   = 7'h2e;
  localparam logic [6:0] ADDR_PIXEL       = 7'h35;
  localparam logic [6:0] ADDR_RES_SEL     = 7'h36;
  // Values after reset
  localparam logic [7:0] RST_LEGACY_CFG   = 8'h00;
  localparam logic [7:0] RST_LASER_DRIVE  = 8'h00;
  localparam logic [1:0] RST_RANGE_COMPL  = 2'h0;
  localparam logic [4:0] RST_FRAME_ACT    = 5'h00;
  localparam logic [7:0] RST_PIXEL        = 8'h00;
  localparam logic [3:0] RST_RES_SEL      = 4'h2;   // Register value 0x04
  // Field positions
  localparam int RANGE_HI      = 7;
  localparam int RANGE_LO      = 6;
  localparam int MODE_HI       = 7;
  localparam int MODE_LO       = 6;
  localparam int ACT_HI        = 4;
  localparam int RES_EN_BIT    = 4;
  localparam int RES_CODE_HI   = 3;
  localparam int RES_CODE_LO   = 1;
  localparam int LEGACY_RES_HI = 3;
  localparam int LEGACY_RES_LO = 1;
  localparam int STAT_PIX_RDY  = 0;
  localparam int STAT_PIX_FST  = 1;
  localparam int STAT_LASER_POWER_VALID_FLAG = 5;
  // Pixel array geometry
  localparam int PIX_COLS  = 20;
  localparam int PIX_ROWS  = 20;
  localparam logic [8:0] PIX_LAST = 9'(PIX_COLS * PIX_ROWS - 1);
  // Frame pacing
  localparam int FRAME_TIME_US = 500;
  localparam int CORE_CLK_MHZ  = 10;
  localparam int FRAME_CYCLES  = FRAME_TIME_US * CORE_CLK_MHZ;
  // Serial framing: address byte then data byte, MSB first
  localparam int         SPI_WRITE_BIT  = 7;
  localparam logic [3:0] SPI_ADDR_DONE  = 4'h7;
  localparam logic [3:0] SPI_DATA_START = 4'h8;
  localparam logic [3:0] SPI_DATA_DONE  = 4'hf;
  // Pixel grab progress
  typedef enum logic [1:0] {PIX_IDLE, PIX_WAIT, PIX_READY} sltrr_pix_e;
endpackage

// ---- include/sltrr_spi_if.sv ----
`timescale 1ns/1ps
// Command handover between the serial clock domain and the core clock domain
interface sltrr_spi_if;
  logic       wr_tgl;
  logic       rd_tgl;
  logic [6:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport port (output wr_tgl, rd_tgl, addr, wdata, input rdata);
  modport core (input wr_tgl, rd_tgl, addr, wdata, output rdata);
endinterface

// ---- tb/sltrr_mcu.sv ----
`timescale 1ns/1ps
module sltrr_mcu (
  output logic      SCLK,
  output logic      CHIP_SEL_N,
  output logic      MOSI,
  input  wire logic MISO
);
  // Serial clock idles high and runs only inside a frame
  initial
  begin
    SCLK = 1'b1;
    CHIP_SEL_N = 1'b1;
    MOSI = 1'b1;
  end
  // One byte each way, MSB first, sampled on the rising edge
  task automatic shift(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--)
    begin
      SCLK = 1'b0;
      MOSI = tx[i];
      #7.5 SCLK = 1'b1;
      rx[i] = MISO;
      #7.5;
    end
  endtask
  // Address byte, gap so the core can fetch, then data byte
  task automatic access(input logic wr, input logic [6:0] a, input logic [7:0] d,
                        output logic [7:0] q);
    logic [7:0] junk;
    CHIP_SEL_N = 1'b0;
    #100 shift({wr, a}, junk);
    #1000 shift(d, q);
    #100 CHIP_SEL_N = 1'b1;
    MOSI = ~MOSI;  // Released line must not keep its last value
    #500;
  endtask
endmodule

// ---- tb/sltrr_regs_top_test.sv ----
`timescale 1ns/1ps
`define CHK(n, e, s) begin n_checks++; if ((s) !== (e)) begin err_count++; \
  $display("wrong value %s exp %h got %h", n, e, s); end end
module sltrr_regs_top_test;
  logic       core_clk, rst, sclk, cs_n, mosi, miso, tick, las_n, lpv, hi;
  logic [1:0] mode;
  logic [7:0] pix_in, q;
  logic [8:0] pix_a;
  logic [2:0] code;
  int         err_count, n_checks;
  sltrr_regs_top #(.FRAME_CYCLES(200)) dut (.CORE_CLK(core_clk), .RST(rst), .SCLK(sclk),
    .CHIP_SEL_N(cs_n), .MOSI(mosi), .MISO(miso), .MISO_OE(), .POWER_MODE(mode),
    .PIXEL_IN(pix_in), .PIXEL_ADDR(pix_a), .FRAME_TICK(tick), .LASER_EN_N(las_n),
    .LASER_POWER_VALID(lpv), .RES_HIGH_SEL(hi), .RES_CODE(code));
  sltrr_mcu mcu (.SCLK(sclk), .CHIP_SEL_N(cs_n), .MOSI(mosi), .MISO(miso));
  assign pix_in = pix_a[7:0] ^ 8'h5a;  // Pixel value tells which address was fetched
  // Core clock
  initial
  begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // Watchdog, well past the roughly 170 microseconds the tests need
  initial
  begin
    #2000000 err_count++;
    end_sim();
  end
  // Tests
  initial
  begin
    rst = 1'b1;
    mode = 2'h2;
    repeat (20) @(negedge core_clk);
    rst = 1'b0;
    repeat (5) @(negedge core_clk);
    mcu.access(0, 7'h36, 0, q); `CHK("res_sel", 8'h04, q)
    mcu.access(1, 7'h1f, 8'hff, q);
    mcu.access(0, 7'h1f, 0, q); `CHK("compl", 8'hc0, q)
    `CHK("laser_power_valid_flag", 1'b1, lpv)
    mcu.access(1, 7'h1a, 8'h40, q);
    `CHK("laser_power_valid_flag", 1'b0, lpv)
    `CHK("laser_n", 1'b1, las_n)
    mcu.access(1, 7'h1f, 8'h80, q);
    `CHK("laser_power_valid_flag", 1'b1, lpv)
    $display("laser test done");
    @(posedge tick);
    @(negedge core_clk);
    mcu.access(1, 7'h2e, 8'h5c, q);
    mcu.access(0, 7'h2e, 0, q); `CHK("obs", 8'h80, q)
    repeat (250) @(negedge core_clk);
    mode = 2'h1;
    mcu.access(0, 7'h2e, 0, q); `CHK("obs", 8'h5f, q)
    $display("activity test done");
    for (int c = 1; c < 4; c++)
    begin
      mcu.access(1, 7'h36, {3'h0, 1'b1, 3'(c), 1'b0}, q);
      `CHK("res_code", 3'(c), code)
    end
    `CHK("res_high", 1'b1, hi)
    mcu.access(1, 7'h12, 8'h04, q);
    mcu.access(1, 7'h36, 8'h06, q);
    `CHK("res_high", 1'b0, hi)
    `CHK("res_code", 3'h2, code)
    $display("resolution test done");
    mcu.access(1, 7'h35, 8'h00, q);
    repeat (500) @(negedge core_clk);
    mcu.access(0, 7'h02, 0, q); `CHK("pix_rdy", 1'b1, q[0])
    `CHK("pix_first", 1'b1, q[1])
    mcu.access(0, 7'h35, 0, q); `CHK("pixel0", 8'h5a, q)
    repeat (500) @(negedge core_clk);
    mcu.access(0, 7'h35, 0, q); `CHK("pixel1", 8'h5b, q)
    $display("pixel test done");
    end_sim();
  end
endmodule
